//--- common/epc_map.vh
// Constants for the eleven-phase pipeline control block
`ifndef EPC_MAP_VH
`define EPC_MAP_VH

// ----------------------------------------------------------------
// Packet and slot geometry
// ----------------------------------------------------------------
`define EPC_SLOTS 8
`define EPC_ADDR_W 32
`define EPC_PKT_W 256
`define EPC_INSTR_W 32
`define EPC_DATA_W 32
`define EPC_REG_W 5

// ----------------------------------------------------------------
// Program address step per fetch packet (bytes) and reset vector
// ----------------------------------------------------------------
`define EPC_PKT_STEP 32'h00000020
`define EPC_RESET_ADDR 32'h00000000

// ----------------------------------------------------------------
// Instruction classes, from the slot class inputs
// ----------------------------------------------------------------
`define EPC_CL_W 3
`define EPC_CL_NOP 3'h0
`define EPC_CL_SINGLE 3'h1
`define EPC_CL_MUL 3'h2
`define EPC_CL_STORE 3'h3
`define EPC_CL_XMUL 3'h4
`define EPC_CL_LOAD 3'h5
`define EPC_CL_BRANCH 3'h6

// ----------------------------------------------------------------
// Control status register saturation bit position
// ----------------------------------------------------------------
`define EPC_SAT_BIT 9
`define EPC_CSR_RESET 32'h00000000

`endif

//--- sim/epc_mem_model.sv
// Program and data memory model facing the pipeline control
`timescale 1ns/1ps
`include "epc_map.vh"
module epc_mem_model (
    // Clock
    input wire i_clk,
    // Program side
    input wire [`EPC_ADDR_W-1:0] i_pmem_addr,
    input wire i_pmem_req,
    output reg [`EPC_PKT_W-1:0] o_pmem_pkt = 256'h0,
    // Data side
    input wire i_dmem_req,
    input wire i_dmem_we,
    input wire [`EPC_SLOTS-1:0] i_dmem_slots,
    output reg [`EPC_SLOTS-1:0] o_dmem_valid = 8'h00
);
    always @(posedge i_clk) begin
        // Read one cycle after the address; a changing pattern when idle
        o_pmem_pkt <= i_pmem_req ? {8{i_pmem_addr}} : ~o_pmem_pkt;
        o_dmem_valid <= (i_dmem_req && !i_dmem_we) ? i_dmem_slots : 8'h00;
    end
endmodule

//--- sim/epc_pipeline_monitor.sv
// Concurrent checks on the pipeline control ports
`timescale 1ns/1ps
`include "epc_map.vh"
module epc_pipeline_monitor (
    // Clock and reset
    input wire I_CORE_CLK,
    input wire I_SRST,
    // Watched outputs
    input wire O_PMEM_REQ,
    input wire [10:0] O_PHASE_VALID,
    input wire [`EPC_SLOTS-1:0] O_UNIT_DISPATCH,
    input wire [`EPC_SLOTS-1:0] O_UNIT_DECODE,
    input wire O_DMEM_REQ,
    input wire O_DMEM_WE,
    input wire [`EPC_SLOTS-1:0] O_DMEM_SLOTS,
    input wire [`EPC_SLOTS-1:0] O_MEM_ACCESS,
    input wire O_SAT_FLAG,
    input wire [`EPC_ADDR_W-1:0] O_CSR
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SRST);
    a_phase_shift: assert property (
        !$past(I_SRST) |-> O_PHASE_VALID[10:1] == $past(O_PHASE_VALID[9:0]))
        else $error("phase occupancy did not shift");
    a_fetch_every: assert property (!$past(I_SRST) |-> O_PHASE_VALID[0])
        else $error("no packet in address generate");
    a_reset_clear: assert property (
        $past(I_SRST) |-> O_PHASE_VALID == 11'h000 && !O_PMEM_REQ && !O_SAT_FLAG)
        else $error("state not empty after reset");
    a_req_send: assert property (O_PMEM_REQ == O_PHASE_VALID[1])
        else $error("fetch request not in send phase");
    a_decode_follow: assert property (
        !$past(I_SRST) |-> O_UNIT_DECODE == $past(O_UNIT_DISPATCH))
        else $error("decode slots differ from dispatch");
    a_store_req: assert property (O_DMEM_WE |-> O_DMEM_REQ)
        else $error("write without data request");
    a_req_slots: assert property (O_DMEM_REQ == (O_DMEM_SLOTS != 8'h00))
        else $error("data request and slots disagree");
    a_access_follow: assert property (
        !$past(I_SRST) |-> O_MEM_ACCESS == $past(O_DMEM_SLOTS))
        else $error("memory access not one cycle after request");
    a_sat_sticky: assert property (O_SAT_FLAG |=> O_SAT_FLAG)
        else $error("saturation flag dropped");
    a_csr_sat: assert property (O_CSR[`EPC_SAT_BIT] == O_SAT_FLAG)
        else $error("status bit differs from flag");
    cover property (O_DMEM_REQ && O_DMEM_WE);
    cover property ($rose(O_SAT_FLAG));
    cover property (O_PHASE_VALID == 11'h7FF);
endmodule
bind epc_pipeline_ctrl epc_pipeline_monitor epc_pipeline_monitor_i (
    .I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .O_PMEM_REQ(O_PMEM_REQ),
    .O_PHASE_VALID(O_PHASE_VALID), .O_UNIT_DISPATCH(O_UNIT_DISPATCH),
    .O_UNIT_DECODE(O_UNIT_DECODE), .O_DMEM_REQ(O_DMEM_REQ), .O_DMEM_WE(O_DMEM_WE),
    .O_DMEM_SLOTS(O_DMEM_SLOTS), .O_MEM_ACCESS(O_MEM_ACCESS),
    .O_SAT_FLAG(O_SAT_FLAG), .O_CSR(O_CSR));

//--- sim/testbench.sv
// Self-checking bench for the pipeline control block
`timescale 1ns/1ps
`include "epc_map.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s: expected %h seen %h", n, e, g); end end
module testbench;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg [23:0] cls = 24'h249249;
    reg [7:0] cond = 8'hFF, sat_s = 8'h00, sat_m = 8'h00;
    reg [31:0] btgt = 32'h00000000;
    integer fail_count = 0, checks = 0, cyc = 0;
    wire [31:0] paddr, control_status_register;
    wire [255:0] pkt, dpkt;
    wire [10:0] phase;
    wire preq, dreq, dwe, sat;
    wire [7:0] slots, dval, disp, dec, opr, agen, wb1, wb2, wb4, wb5, mem, arr;
    // ----------------------------------------------------------------
    // Design, memory model and clock
    // ----------------------------------------------------------------
    epc_pipeline_ctrl epc_pipeline_ctrl_i (.I_CORE_CLK(clk), .I_SRST(srst),
        .O_PMEM_ADDR(paddr), .O_PMEM_REQ(preq), .I_PMEM_PKT(pkt), .I_SLOT_CLASS(cls),
        .I_COND_TRUE(cond), .I_SAT_SINGLE(sat_s), .I_SAT_MUL(sat_m),
        .I_BRANCH_TARGET(btgt), .O_DMEM_REQ(dreq), .O_DMEM_WE(dwe), .O_DMEM_SLOTS(slots),
        .I_DMEM_DATA_VALID(dval), .O_UNIT_DISPATCH(disp), .O_DISPATCH_PKT(dpkt),
        .O_UNIT_DECODE(dec), .O_OPERAND_READ(opr), .O_ADDR_GEN(agen), .O_WB_E1(wb1),
        .O_WB_E2(wb2), .O_WB_E4(wb4), .O_WB_E5(wb5), .O_MEM_ACCESS(mem),
        .O_LOAD_ARRIVE(arr), .O_PHASE_VALID(phase), .O_SAT_FLAG(sat), .O_CSR(control_status_register));
    epc_mem_model epc_mem_model_i (.i_clk(clk), .i_pmem_addr(paddr), .i_pmem_req(preq),
        .o_pmem_pkt(pkt), .i_dmem_req(dreq), .i_dmem_we(dwe), .i_dmem_slots(slots),
        .o_dmem_valid(dval));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count++;
            complete_run;
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task do_reset;
        begin
            @(posedge clk);
            srst <= 1'b1;
            repeat (6) @(posedge clk);
            srst <= 1'b0;
        end
    endtask
    task t_fill;
        integer k;
        reg [31:0] a;
        begin
            for (k = 1; k < 12; k++) begin
                @(posedge clk);
                @(negedge clk);
                `CHK("occupancy", (11'h001 << k) - 11'h001, phase)
                if (k > 1)
                    `CHK("fetch addr", `EPC_RESET_ADDR + (k - 2) * `EPC_PKT_STEP, paddr)
                a = `EPC_RESET_ADDR + (k - 5) * `EPC_PKT_STEP;
                if (k > 4)
                    `CHK("dispatch pkt", {8{a}}, dpkt)
            end
        end
    endtask
    // Fields: dispatch, addr gen, wb1, wb2, wb4, wb5, mem access, load arrive
    task t_steady(input [2:0] c, input [7:0] cnd, input [63:0] e, input [7:0] m);
        integer k;
        reg [63:0] got;
        begin
            @(posedge clk);
            cls <= {8{c}};
            cond <= cnd;
            repeat (14) @(posedge clk);
            @(negedge clk);
            got = {disp, agen, wb1, wb2, wb4, wb5, mem, arr};
            for (k = 0; k < 8; k++)
                if (m[k])
                    `CHK("strobe byte", e[k*8+:8], got[k*8+:8])
        end
    endtask
    task t_sat;
        begin
            do_reset;
            repeat (14) @(posedge clk);
            sat_m <= 8'h02;
            repeat (3) @(posedge clk);
            sat_m <= 8'h00;
            repeat (6) @(negedge clk);
            `CHK("sat flag", 1'b0, sat)
            @(posedge clk);
            cls <= {8{`EPC_CL_SINGLE}};
            repeat (12) @(posedge clk);
            sat_s <= 8'h01;
            repeat (3) @(posedge clk);
            sat_s <= 8'h00;
            repeat (6) @(negedge clk);
            `CHK("csr sat", 1'b1, control_status_register[`EPC_SAT_BIT])
            `CHK("sat flag", 1'b1, sat)
            do_reset;
            repeat (2) @(negedge clk);
            `CHK("sat flag", 1'b0, sat)
            t_steady(`EPC_CL_MUL, 8'hFF, 64'hFF0000FF00000000, 8'hFF);
            @(posedge clk);
            sat_m <= 8'h02;
            repeat (3) @(posedge clk);
            sat_m <= 8'h00;
            repeat (6) @(negedge clk);
            `CHK("sat flag", 1'b1, sat)
        end
    endtask
    initial begin
        do_reset;
        t_fill;
        t_steady(`EPC_CL_SINGLE, 8'hFF, 64'hFF00FF0000000000, 8'hFF);
        t_steady(`EPC_CL_NOP, 8'hFF, 64'h0, 8'hFF);
        t_steady(`EPC_CL_STORE, 8'hFF, 64'hFFFF000000000000 | 64'hFF00, 8'hDF);
        t_steady(`EPC_CL_XMUL, 8'hFF, 64'hFF000000FF000000, 8'hFF);
        t_steady(`EPC_CL_LOAD, 8'hFF, 64'hFFFF00000000FFFF | 64'hFF0000, 8'hDF);
        t_steady(`EPC_CL_LOAD, 8'h0F, 64'hFF000000000F0F0F, 8'h9F);
        btgt <= 32'h00001040;
        t_steady(`EPC_CL_BRANCH, 8'hFF, 64'hFF00000000000000, 8'hDF);
        `CHK("branch addr", btgt, paddr)
        t_sat;
        complete_run;
    end
    task complete_run;
        begin
            $display("checks %0d fail_count %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
endmodule

//--- src/epc_pipeline_ctrl.v
// Phase sequencing control for an eight-wide, eleven-phase pipeline
//
// Behaviour
// - Packets move one phase per cycle in lockstep; a new packet enters each cycle.
// - A packet generated in cycle 1 reaches first execute in cycle 7.
// - A fully parallel fetch packet forms one execute packet without stall.
// - Program address generate phase computes the next fetch packet address.
// - Program address send phase drives the address to program memory.
// - The full fetch packet is at the boundary in the receive phase.
// - Dispatch routes each instruction of the execute packet to its unit.
// - Decode phase decodes each dispatched instruction in its unit.
// - First execute evaluates every condition and reads operands.
// - Loads and stores generate address and write pointer update in first execute.
// - A branch in first execute redirects the packet in address generate.
// - Single-cycle instructions write results in first execute and complete.
// - Second execute sends load address, or store address and data, to memory.
// - Saturating single-cycle result sets the saturation flag in second execute.
// - Single multiplies and multiply-unit non-multiplies write back in second execute.
// - Data memory access happens in third execute; stores complete there.
// - Saturating multiply result sets the saturation flag in third execute.
// - Load data arrives from data memory in fourth execute.
// - Extended multiplies write results in fourth execute.
// - Loads write returned data into the destination in fifth execute.
// - False-condition instructions do nothing after first execute.
// - Every phase step begins and ends on a clock edge.
// - No-operation slots are never assigned to a functional unit.
// - Most instructions use only first execute; few use later phases.
`timescale 1ns/1ps
`include "epc_map.vh"

module epc_pipeline_ctrl (
    // Clock and reset
    input wire I_CORE_CLK,
    input wire I_SRST,
    // Program memory
    output reg [`EPC_ADDR_W-1:0] O_PMEM_ADDR,
    output reg O_PMEM_REQ,
    input wire [`EPC_PKT_W-1:0] I_PMEM_PKT,
    // Slot classification of the received packet
    input wire [`EPC_SLOTS*`EPC_CL_W-1:0] I_SLOT_CLASS,
    // Condition results and saturation indications from the units
    input wire [`EPC_SLOTS-1:0] I_COND_TRUE,
    input wire [`EPC_SLOTS-1:0] I_SAT_SINGLE,
    input wire [`EPC_SLOTS-1:0] I_SAT_MUL,
    // Branch target from the unit executing a branch
    input wire [`EPC_ADDR_W-1:0] I_BRANCH_TARGET,
    // Data memory
    output reg O_DMEM_REQ,
    output reg O_DMEM_WE,
    output reg [`EPC_SLOTS-1:0] O_DMEM_SLOTS,
    input wire [`EPC_SLOTS-1:0] I_DMEM_DATA_VALID,
    // Functional unit control
    output reg [`EPC_SLOTS-1:0] O_UNIT_DISPATCH,
    output reg [`EPC_PKT_W-1:0] O_DISPATCH_PKT,
    output reg [`EPC_SLOTS-1:0] O_UNIT_DECODE,
    output reg [`EPC_SLOTS-1:0] O_OPERAND_READ,
    output reg [`EPC_SLOTS-1:0] O_ADDR_GEN,
    output reg [`EPC_SLOTS-1:0] O_WB_E1,
    output reg [`EPC_SLOTS-1:0] O_WB_E2,
    output reg [`EPC_SLOTS-1:0] O_WB_E4,
    output reg [`EPC_SLOTS-1:0] O_WB_E5,
    output reg [`EPC_SLOTS-1:0] O_MEM_ACCESS,
    output reg [`EPC_SLOTS-1:0] O_LOAD_ARRIVE,
    // Phase occupancy, saturation flag and control status register
    output wire [10:0] O_PHASE_VALID,
    output reg O_SAT_FLAG,
    output wire [`EPC_ADDR_W-1:0] O_CSR
);

    // ----------------------------------------------------------------
    // Phase occupancy and per-slot state
    // ----------------------------------------------------------------
    reg v_pg, v_ps, v_pw, v_pr, v_dp, v_dc, v_e1, v_e2, v_e3, v_e4, v_e5;
    reg [`EPC_ADDR_W-1:0] pg_addr;
    reg [`EPC_PKT_W-1:0] pr_pkt;
    reg [`EPC_SLOTS*`EPC_CL_W-1:0] pr_cls, dp_cls, dc_cls, e1_cls;
    reg [`EPC_SLOTS*`EPC_CL_W-1:0] e2_cls, e3_cls, e4_cls;
    reg [`EPC_SLOTS-1:0] e2_live, e3_live, e4_live;
    reg [`EPC_SLOTS-1:0] e2_sat, e3_sat;
    reg [`EPC_ADDR_W-1:0] control_status_register;
    reg [`EPC_ADDR_W-1:0] next_pg_addr;
    reg [`EPC_ADDR_W-1:0] cur_pg_addr;
    reg [`EPC_SLOTS-1:0] br_hit;
    reg [`EPC_SLOTS-1:0] m_e1_live, m_single, m_mul, m_st, m_xmul, m_ld, m_ldst;
    reg [`EPC_SLOTS-1:0] m_dp, m_e2_ldst, m_e2_st, m_e2_mul, m_e3_ldst, m_e3_mul;
    reg [`EPC_SLOTS-1:0] m_e4_ld, m_e4_xmul, m_e4_live_ld;
    integer k;

    assign O_PHASE_VALID = {v_e5, v_e4, v_e3, v_e2, v_e1, v_dc, v_dp, v_pr, v_pw, v_ps, v_pg};
    assign O_CSR = control_status_register;

    // ----------------------------------------------------------------
    // Slot class decode
    // ----------------------------------------------------------------
    function [`EPC_SLOTS-1:0] cls_is;
        input [`EPC_SLOTS*`EPC_CL_W-1:0] cls;
        input [`EPC_CL_W-1:0] code;
        integer j;
        begin
            for (j = 0; j < `EPC_SLOTS; j = j + 1) begin
                cls_is[j] = (cls[j*`EPC_CL_W +: `EPC_CL_W] == code);
            end
        end
    endfunction

    always @* begin
        // Non-empty slots are dispatched; no-operation slots stay empty
        m_dp = ~cls_is(dp_cls, `EPC_CL_NOP);
        m_e1_live = I_COND_TRUE & ~cls_is(e1_cls, `EPC_CL_NOP);
        m_single = m_e1_live & cls_is(e1_cls, `EPC_CL_SINGLE);
        m_mul = m_e1_live & cls_is(e1_cls, `EPC_CL_MUL);
        m_st = m_e1_live & cls_is(e1_cls, `EPC_CL_STORE);
        m_xmul = m_e1_live & cls_is(e1_cls, `EPC_CL_XMUL);
        m_ld = m_e1_live & cls_is(e1_cls, `EPC_CL_LOAD);
        m_ldst = m_st | m_ld;
        br_hit = m_e1_live & cls_is(e1_cls, `EPC_CL_BRANCH);
        m_e2_st = e2_live & cls_is(e2_cls, `EPC_CL_STORE);
        m_e2_ldst = m_e2_st | (e2_live & cls_is(e2_cls, `EPC_CL_LOAD));
        m_e2_mul = e2_live & cls_is(e2_cls, `EPC_CL_MUL);
        m_e3_ldst = e3_live & (cls_is(e3_cls, `EPC_CL_STORE) | cls_is(e3_cls, `EPC_CL_LOAD));
        m_e3_mul = e3_live & (cls_is(e3_cls, `EPC_CL_MUL) | cls_is(e3_cls, `EPC_CL_XMUL));
        m_e4_ld = e4_live & cls_is(e4_cls, `EPC_CL_LOAD);
        m_e4_xmul = e4_live & cls_is(e4_cls, `EPC_CL_XMUL);
        m_e4_live_ld = m_e4_ld;
        // Branch in first execute redirects the packet now in address generate
        cur_pg_addr = pg_addr;
        if (v_e1 && (br_hit != 8'h00)) begin
            cur_pg_addr = I_BRANCH_TARGET;
        end
        next_pg_addr = cur_pg_addr + `EPC_PKT_STEP;
    end

    // ----------------------------------------------------------------
    // Lockstep phase advance, one phase per clock
    // ----------------------------------------------------------------
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            v_pg <= 1'b0;
            v_ps <= 1'b0;
            v_pw <= 1'b0;
            v_pr <= 1'b0;
            v_dp <= 1'b0;
            v_dc <= 1'b0;
            v_e1 <= 1'b0;
            v_e2 <= 1'b0;
            v_e3 <= 1'b0;
            v_e4 <= 1'b0;
            v_e5 <= 1'b0;
            pg_addr <= `EPC_RESET_ADDR;
            pr_pkt <= 256'h0;
            pr_cls <= 24'h0;
            dp_cls <= 24'h0;
            dc_cls <= 24'h0;
            e1_cls <= 24'h0;
            e2_cls <= 24'h0;
            e3_cls <= 24'h0;
            e4_cls <= 24'h0;
            e2_live <= 8'h00;
            e3_live <= 8'h00;
            e4_live <= 8'h00;
            e2_sat <= 8'h00;
            e3_sat <= 8'h00;
        end else begin
            // A new packet enters each cycle and all advance together
            v_pg <= 1'b1;
            v_ps <= v_pg;
            v_pw <= v_ps;
            v_pr <= v_pw;
            v_dp <= v_pr;
            v_dc <= v_dp;
            v_e1 <= v_dc;
            v_e2 <= v_e1;
            v_e3 <= v_e2;
            v_e4 <= v_e3;
            v_e5 <= v_e4;
            if (v_pg) begin
                pg_addr <= next_pg_addr;
            end
            // Packet captured at the boundary in the receive phase
            pr_pkt <= I_PMEM_PKT;
            pr_cls <= I_SLOT_CLASS;
            // Whole fetch packet is one execute packet: no dispatch stall
            dp_cls <= pr_cls;
            dc_cls <= dp_cls;
            e1_cls <= dc_cls;
            e2_cls <= e1_cls;
            e3_cls <= e2_cls;
            e4_cls <= e3_cls;
            // False-condition slots drop out after first execute
            e2_live <= v_e1 ? m_e1_live : 8'h00;
            e3_live <= v_e2 ? e2_live : 8'h00;
            e4_live <= v_e3 ? e3_live : 8'h00;
            e2_sat <= v_e1 ? (m_single & I_SAT_SINGLE) : 8'h00;
            e3_sat <= v_e2 ? (m_e2_mul | (e2_live & cls_is(e2_cls, `EPC_CL_XMUL))) : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Per-phase control outputs
    // ----------------------------------------------------------------
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_PMEM_ADDR <= `EPC_RESET_ADDR;
            O_PMEM_REQ <= 1'b0;
            O_DMEM_REQ <= 1'b0;
            O_DMEM_WE <= 1'b0;
            O_DMEM_SLOTS <= 8'h00;
            O_UNIT_DISPATCH <= 8'h00;
            O_DISPATCH_PKT <= 256'h0;
            O_UNIT_DECODE <= 8'h00;
            O_OPERAND_READ <= 8'h00;
            O_ADDR_GEN <= 8'h00;
            O_WB_E1 <= 8'h00;
            O_WB_E2 <= 8'h00;
            O_WB_E4 <= 8'h00;
            O_WB_E5 <= 8'h00;
            O_MEM_ACCESS <= 8'h00;
            O_LOAD_ARRIVE <= 8'h00;
        end else begin
            // Address moves to send phase; memory reads it one cycle later
            O_PMEM_ADDR <= cur_pg_addr;
            O_PMEM_REQ <= v_pg;
            O_UNIT_DISPATCH <= v_pr ? ~cls_is(pr_cls, `EPC_CL_NOP) : 8'h00;
            O_DISPATCH_PKT <= pr_pkt;
            O_UNIT_DECODE <= v_dp ? m_dp : 8'h00;
            O_OPERAND_READ <= v_dc ? ~cls_is(dc_cls, `EPC_CL_NOP) : 8'h00;
            O_ADDR_GEN <= v_e1 ? m_ldst : 8'h00;
            O_WB_E1 <= v_e1 ? (m_single | m_ldst) : 8'h00;
            O_WB_E2 <= v_e2 ? m_e2_mul : 8'h00;
            O_DMEM_REQ <= v_e2 && (m_e2_ldst != 8'h00);
            O_DMEM_WE <= v_e2 && (m_e2_st != 8'h00);
            O_DMEM_SLOTS <= v_e2 ? m_e2_ldst : 8'h00;
            O_MEM_ACCESS <= v_e3 ? m_e3_ldst : 8'h00;
            O_LOAD_ARRIVE <= v_e4 ? (m_e4_ld & I_DMEM_DATA_VALID) : 8'h00;
            O_WB_E4 <= v_e4 ? m_e4_xmul : 8'h00;
            O_WB_E5 <= v_e4 ? m_e4_live_ld : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Saturation flag in the control status register
    // ----------------------------------------------------------------
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            control_status_register <= `EPC_CSR_RESET;
            O_SAT_FLAG <= 1'b0;
        end else begin
            if ((v_e2 && (e2_sat != 8'h00)) ||
                (v_e3 && ((e3_sat & I_SAT_MUL) != 8'h00))) begin
                control_status_register[`EPC_SAT_BIT] <= 1'b1;
                O_SAT_FLAG <= 1'b1;
            end
        end
    end

endmodule
